// ==== hw/sbrg_pkg.sv ====
// Purpose: Shared constants and types of the serial baud timer block
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word per register
// Notes: All registers except the 16-bit timer count are 8 bits wide and sit in the low byte lane
package sbrg_pkg;

   localparam int SBRG_ADDR_W = 8;
   localparam int SBRG_DATA_W = 32;
   localparam int SBRG_REG_W = 8;
   localparam int SBRG_DIV_W = 16;
   localparam int SBRG_PRE_W = 6;

   // Register byte addresses
   localparam logic [SBRG_ADDR_W-1:0] SBRG_BAUD_CONTROL_ADDR = 8'h00;
   localparam logic [SBRG_ADDR_W-1:0] SBRG_RECEIVE_STATUS_CONTROL_ADDR = 8'h04;
   localparam logic [SBRG_ADDR_W-1:0] SBRG_DIVISOR_LOW_BYTE_ADDR = 8'h08;
   localparam logic [SBRG_ADDR_W-1:0] SBRG_DIVISOR_HIGH_BYTE_ADDR = 8'h0C;
   localparam logic [SBRG_ADDR_W-1:0] SBRG_TRANSMIT_STATUS_CONTROL_ADDR = 8'h10;
   localparam logic [SBRG_ADDR_W-1:0] SBRG_TIMER_COUNT_ADDR = 8'h14;

   // Baud control fields
   localparam int SBRG_AUTOBAUD_OVERFLOW_BIT = 7;
   localparam int SBRG_RECEIVE_IDLE_BIT = 6;
   localparam int SBRG_CLOCK_POLARITY_BIT = 4;
   localparam int SBRG_WIDE_COUNTER_SELECT_BIT = 3;
   localparam int SBRG_WAKE_ENABLE_BIT = 1;
   localparam int SBRG_AUTOBAUD_ENABLE_BIT = 0;
   localparam logic [SBRG_REG_W-1:0] SBRG_BAUD_CONTROL_WMASK = 8'h1B;

   // Transmit status control fields
   localparam int SBRG_SYNC_MODE_BIT = 4;
   localparam int SBRG_HIGH_SPEED_SELECT_BIT = 2;
   localparam int SBRG_SHIFT_EMPTY_BIT = 1;
   localparam logic [SBRG_REG_W-1:0] SBRG_TRANSMIT_STATUS_CONTROL_WMASK = 8'hFD;

   // Receive status control fields
   localparam int SBRG_FRAME_ERROR_BIT = 2;
   localparam int SBRG_OVERRUN_ERROR_BIT = 1;
   localparam logic [SBRG_REG_W-1:0] SBRG_RECEIVE_STATUS_CONTROL_WMASK = 8'hF9;

   // Reset values
   localparam logic [SBRG_REG_W-1:0] SBRG_REG_RESET = 8'h00;
   localparam logic [SBRG_DATA_W-1:0] SBRG_READ_ZERO = 32'h00000000;

   // Prescale limits: multiplier minus one
   localparam logic [SBRG_PRE_W-1:0] SBRG_PRE_LIMIT_64 = 6'h3F;
   localparam logic [SBRG_PRE_W-1:0] SBRG_PRE_LIMIT_16 = 6'h0F;
   localparam logic [SBRG_PRE_W-1:0] SBRG_PRE_LIMIT_4 = 6'h03;

   typedef struct packed {
      logic read;
      logic write;
      logic [SBRG_ADDR_W-1:0] address;
      logic [3:0] byteenable;
      logic [SBRG_DATA_W-1:0] writedata;
   } sbrg_avl_req_s;

   typedef struct packed {
      logic ack;
      logic [SBRG_DATA_W-1:0] readdata;
      logic [SBRG_REG_W-1:0] baud_control;
      logic [SBRG_REG_W-1:0] receive_status_control;
      logic [SBRG_REG_W-1:0] divisor_low_byte;
      logic [SBRG_REG_W-1:0] divisor_high_byte;
      logic [SBRG_REG_W-1:0] transmit_status_control;
      logic baud_tick;
   } sbrg_top_state_s;

endpackage

// ==== hw/sbrg_divider.sv ====
// Purpose: Free running counter from zero to a limit with a terminal pulse
// Assumes: Limit may change at any time; a count at or above it ends the period
// Notes: Clear has priority over counting
`timescale 1ns/1ps
module sbrg_divider #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // Control
   input wire logic i_clear,
   input wire logic i_enable,
   input wire logic [W-1:0] i_limit,
   // Status
   output logic [W-1:0] o_count,
   output logic o_terminal
);

   typedef struct packed {
      logic [W-1:0] count;
   } sbrg_div_state_s;

   sbrg_div_state_s st;
   sbrg_div_state_s next_st;

   assign o_terminal = i_enable && (st.count >= i_limit);
   assign o_count = st.count;

   always_comb begin
      next_st = st;
      if (i_clear) begin
         next_st.count = '0;
      end else if (o_terminal) begin
         next_st.count = '0;
      end else if (i_enable) begin
         next_st.count = st.count + W'(1);
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule // sbrg_divider

// ==== hw/sbrg_top.sv ====
// Purpose: Baud timer of a serial transceiver with its register file
// Assumes: Avalon-MM slave with one wait state; receiver and transmitter sit outside
// Notes: Tick is a one-cycle pulse every prescale times (n+1) clocks
// How it works
// - One baud timer, 8 or 16 bits wide, serves asynchronous and synchronous modes.
// - The timer starts as 8 bits after reset and the wide counter select bit makes it 16 bits.
// - The timer runs freely and its period comes from n, the low divisor byte in 8-bit mode or both divisor bytes in 16-bit mode.
// - In asynchronous mode the prescale depends on both high speed and wide counter bits.
// - In synchronous mode the high speed select bit is ignored.
// - Any write to a divisor byte clears the timer at once so the new rate starts at once.
// - Asynchronous, 8 bits, normal speed gives clock over 64 times (n+1).
// - Asynchronous, 16 bits, normal speed gives clock over 16 times (n+1).
// - Synchronous mode of either width gives clock over 4 times (n+1).
// - The low divisor byte forms bits 7 to 0 of n and, in 16-bit mode only, the high byte bits 15 to 8.
// - Unimplemented bits of the baud registers read as zero.
`timescale 1ns/1ps
module sbrg_top (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // Register bus
   input wire sbrg_pkg::sbrg_avl_req_s i_avl,
   output logic o_avl_waitrequest,
   output logic [sbrg_pkg::SBRG_DATA_W-1:0] o_avl_readdata,
   // Status from transceiver
   input wire logic i_receive_idle_flag,
   input wire logic i_autobaud_overflow,
   input wire logic i_transmit_shift_empty,
   input wire logic i_frame_error,
   input wire logic i_overrun_error,
   // Baud timer outputs
   output logic o_baud_tick,
   output logic [sbrg_pkg::SBRG_DIV_W-1:0] o_divisor,
   output logic o_sync_mode,
   output logic o_high_speed_select,
   output logic o_wide_counter_select,
   // Configuration to transceiver
   output logic o_clock_polarity,
   output logic o_wake_enable,
   output logic o_autobaud_enable,
   output logic [sbrg_pkg::SBRG_REG_W-1:0] o_transmit_status_control,
   output logic [sbrg_pkg::SBRG_REG_W-1:0] o_receive_status_control
);
   import sbrg_pkg::*;

   sbrg_top_state_s st;
   sbrg_top_state_s next_st;

   logic bus_req;
   logic bus_take;
   logic wr_take;
   logic lane0;
   logic divisor_write;
   logic sync_mode;
   logic high_speed;
   logic wide_counter;
   logic [SBRG_DIV_W-1:0] divisor;
   logic [SBRG_PRE_W-1:0] pre_limit;
   logic pre_terminal;
   logic baud_terminal;
   logic [SBRG_PRE_W-1:0] pre_count;
   logic [SBRG_DIV_W-1:0] baud_count;
   logic [SBRG_REG_W-1:0] baud_control_view;
   logic [SBRG_REG_W-1:0] transmit_view;
   logic [SBRG_REG_W-1:0] receive_view;
   logic [SBRG_DATA_W-1:0] read_value;

   // Bus request held until the acknowledge cycle
   assign bus_req = i_avl.read || i_avl.write;
   assign bus_take = bus_req && st.ack;
   assign wr_take = bus_take && i_avl.write;
   assign lane0 = i_avl.byteenable[0];
   assign o_avl_waitrequest = bus_req && !st.ack;
   assign o_avl_readdata = st.readdata;

   // Mode bits
   assign sync_mode = st.transmit_status_control[SBRG_SYNC_MODE_BIT];
   assign high_speed = st.transmit_status_control[SBRG_HIGH_SPEED_SELECT_BIT];
   assign wide_counter = st.baud_control[SBRG_WIDE_COUNTER_SELECT_BIT];

   // Count n: high byte only in wide mode
   always_comb begin
      divisor = {st.divisor_high_byte, st.divisor_low_byte};
      if (!wide_counter) begin
         divisor = {SBRG_REG_RESET, st.divisor_low_byte};
      end
   end

   // Prescale selection
   always_comb begin
      pre_limit = SBRG_PRE_LIMIT_64;
      if (sync_mode) begin
         pre_limit = SBRG_PRE_LIMIT_4;
      end else if (wide_counter) begin
         if (high_speed) begin
            pre_limit = SBRG_PRE_LIMIT_4;
         end else begin
            pre_limit = SBRG_PRE_LIMIT_16;
         end
      end else begin
         if (high_speed) begin
            pre_limit = SBRG_PRE_LIMIT_16;
         end else begin
            pre_limit = SBRG_PRE_LIMIT_64;
         end
      end
   end

   // Either divisor byte written on lane zero
   assign divisor_write = wr_take && lane0 &&
      ((i_avl.address == SBRG_DIVISOR_LOW_BYTE_ADDR) ||
       (i_avl.address == SBRG_DIVISOR_HIGH_BYTE_ADDR));

   // Prescaler, one pulse every multiplier clocks
   sbrg_divider #(
      .W(SBRG_PRE_W)
   ) u_prescale (
      .i_mclk(i_mclk),
      .i_reset_n(i_reset_n),
      .i_clear(divisor_write),
      .i_enable(1'b1),
      .i_limit(pre_limit),
      .o_count(pre_count),
      .o_terminal(pre_terminal)
   );

   // Baud timer counting prescale pulses from zero to n
   sbrg_divider #(
      .W(SBRG_DIV_W)
   ) u_baud_timer (
      .i_mclk(i_mclk),
      .i_reset_n(i_reset_n),
      .i_clear(divisor_write),
      .i_enable(pre_terminal),
      .i_limit(divisor),
      .o_count(baud_count),
      .o_terminal(baud_terminal)
   );

   // Read views with live status bits
   always_comb begin
      baud_control_view = st.baud_control & SBRG_BAUD_CONTROL_WMASK;
      baud_control_view[SBRG_AUTOBAUD_OVERFLOW_BIT] = i_autobaud_overflow;
      baud_control_view[SBRG_RECEIVE_IDLE_BIT] = i_receive_idle_flag;
   end

   always_comb begin
      transmit_view = st.transmit_status_control & SBRG_TRANSMIT_STATUS_CONTROL_WMASK;
      transmit_view[SBRG_SHIFT_EMPTY_BIT] = i_transmit_shift_empty;
   end

   always_comb begin
      receive_view = st.receive_status_control & SBRG_RECEIVE_STATUS_CONTROL_WMASK;
      receive_view[SBRG_FRAME_ERROR_BIT] = i_frame_error;
      receive_view[SBRG_OVERRUN_ERROR_BIT] = i_overrun_error;
   end

   // Read multiplexer; unmapped reads return zero
   always_comb begin
      read_value = SBRG_READ_ZERO;
      case (i_avl.address)
         SBRG_BAUD_CONTROL_ADDR: begin
            read_value[SBRG_REG_W-1:0] = baud_control_view;
         end
         SBRG_RECEIVE_STATUS_CONTROL_ADDR: begin
            read_value[SBRG_REG_W-1:0] = receive_view;
         end
         SBRG_DIVISOR_LOW_BYTE_ADDR: begin
            read_value[SBRG_REG_W-1:0] = st.divisor_low_byte;
         end
         SBRG_DIVISOR_HIGH_BYTE_ADDR: begin
            read_value[SBRG_REG_W-1:0] = st.divisor_high_byte;
         end
         SBRG_TRANSMIT_STATUS_CONTROL_ADDR: begin
            read_value[SBRG_REG_W-1:0] = transmit_view;
         end
         SBRG_TIMER_COUNT_ADDR: begin
            read_value[SBRG_DIV_W-1:0] = baud_count;
         end
         default: begin
            read_value = SBRG_READ_ZERO;
         end
      endcase
   end

   // Next state
   always_comb begin
      next_st = st;
      next_st.baud_tick = baud_terminal;
      // Acknowledge one cycle after the request appears
      next_st.ack = bus_req && !st.ack;
      if (bus_req && !st.ack && i_avl.read) begin
         next_st.readdata = read_value;
      end
      if (wr_take && lane0) begin
         case (i_avl.address)
            SBRG_BAUD_CONTROL_ADDR: begin
               next_st.baud_control =
                  i_avl.writedata[SBRG_REG_W-1:0] & SBRG_BAUD_CONTROL_WMASK;
            end
            SBRG_RECEIVE_STATUS_CONTROL_ADDR: begin
               next_st.receive_status_control =
                  i_avl.writedata[SBRG_REG_W-1:0] & SBRG_RECEIVE_STATUS_CONTROL_WMASK;
            end
            SBRG_DIVISOR_LOW_BYTE_ADDR: begin
               next_st.divisor_low_byte = i_avl.writedata[SBRG_REG_W-1:0];
            end
            SBRG_DIVISOR_HIGH_BYTE_ADDR: begin
               next_st.divisor_high_byte = i_avl.writedata[SBRG_REG_W-1:0];
            end
            SBRG_TRANSMIT_STATUS_CONTROL_ADDR: begin
               next_st.transmit_status_control =
                  i_avl.writedata[SBRG_REG_W-1:0] & SBRG_TRANSMIT_STATUS_CONTROL_WMASK;
            end
            default: begin
               next_st.ack = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs
   assign o_baud_tick = st.baud_tick;
   assign o_divisor = divisor;
   assign o_sync_mode = sync_mode;
   assign o_high_speed_select = high_speed;
   assign o_wide_counter_select = wide_counter;
   assign o_clock_polarity = st.baud_control[SBRG_CLOCK_POLARITY_BIT];
   assign o_wake_enable = st.baud_control[SBRG_WAKE_ENABLE_BIT];
   assign o_autobaud_enable = st.baud_control[SBRG_AUTOBAUD_ENABLE_BIT];
   assign o_transmit_status_control = st.transmit_status_control;
   assign o_receive_status_control = st.receive_status_control;

endmodule // sbrg_top

// ==== bench/sbrg_monitor.sv ====
// Purpose: Port assertions of the baud timer
// Assumes: Sees only the ports of sbrg_top
// Notes: Rate checks skip any period broken by a register write
`timescale 1ns/1ps
module sbrg_monitor
   import sbrg_pkg::*;
(
   // Clock, reset and bus
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire sbrg_pkg::sbrg_avl_req_s i_avl,
   input wire logic o_avl_waitrequest,
   input wire logic [sbrg_pkg::SBRG_DATA_W-1:0] o_avl_readdata,
   // Timer
   input wire logic o_baud_tick,
   input wire logic [sbrg_pkg::SBRG_DIV_W-1:0] o_divisor,
   input wire logic o_sync_mode,
   input wire logic o_high_speed_select,
   input wire logic o_wide_counter_select
);
   logic take_wr;
   logic clean;
   int gap;
   assign take_wr = i_avl.write && !o_avl_waitrequest;
   // Cycles since last tick, and whether no write broke the period
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         gap <= 0;
         clean <= 1'b0;
      end else begin
         gap <= o_baud_tick ? 0 : gap + 1;
         clean <= take_wr ? 1'b0 : (o_baud_tick ? 1'b1 : clean);
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   sequence s_div_take;
      take_wr && i_avl.byteenable[0] && (i_avl.address == SBRG_DIVISOR_LOW_BYTE_ADDR
         || i_avl.address == SBRG_DIVISOR_HIGH_BYTE_ADDR);
   endsequence
   sequence s_quiet;
      !o_baud_tick [*3];
   endsequence
   property p_div_clear;
      s_div_take |-> ##2 s_quiet;
   endproperty
   property p_tick_pulse;
      o_baud_tick |=> !o_baud_tick;
   endproperty
   property p_div8;
      !o_wide_counter_select |-> o_divisor[15:8] == 8'h00;
   endproperty
   property p_wide_reset;
      $rose(i_reset_n) |-> !o_wide_counter_select;
   endproperty
   property p_bc_zero;
      i_avl.read && !o_avl_waitrequest && i_avl.address == SBRG_BAUD_CONTROL_ADDR
         |-> o_avl_readdata[5] == 1'b0 && o_avl_readdata[2] == 1'b0
         && o_avl_readdata[31:8] == 24'h000000;
   endproperty
   property p_rate64;
      o_baud_tick && clean && !o_sync_mode && !o_wide_counter_select && !o_high_speed_select
         |-> gap + 1 == 64 * (int'(o_divisor) + 1);
   endproperty
   property p_rate16;
      o_baud_tick && clean && !o_sync_mode && o_wide_counter_select && !o_high_speed_select
         |-> gap + 1 == 16 * (int'(o_divisor) + 1);
   endproperty
   property p_rate4s;
      o_baud_tick && clean && o_sync_mode |-> gap + 1 == 4 * (int'(o_divisor) + 1);
   endproperty
   property p_ratehs;
      o_baud_tick && clean && !o_sync_mode && o_high_speed_select
         |-> gap + 1 == (o_wide_counter_select ? 4 : 16) * (int'(o_divisor) + 1);
   endproperty
   a_div_clear: assert property (p_div_clear) else $error("tick too soon after divisor write");
   a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");
   a_div8: assert property (p_div8) else $error("high byte used in 8-bit mode");
   a_wide_reset: assert property (p_wide_reset) else $error("timer not 8-bit after reset");
   a_bc_zero: assert property (p_bc_zero) else $error("unused bits read nonzero");
   a_rate64: assert property (p_rate64) else $error("period not 64 times n+1");
   a_rate16: assert property (p_rate16) else $error("period not 16 times n+1");
   a_rate4s: assert property (p_rate4s) else $error("sync period not 4 times n+1");
   a_ratehs: assert property (p_ratehs) else $error("high speed period wrong");
endmodule // sbrg_monitor

bind sbrg_top sbrg_monitor u_monitor (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_avl(i_avl),
   .o_avl_waitrequest(o_avl_waitrequest), .o_avl_readdata(o_avl_readdata),
   .o_baud_tick(o_baud_tick), .o_divisor(o_divisor), .o_sync_mode(o_sync_mode),
   .o_high_speed_select(o_high_speed_select), .o_wide_counter_select(o_wide_counter_select));

// ==== bench/sbrg_top_test.sv ====
// Purpose: Self-checking bench of the baud timer
// Assumes: One wait state bus, status inputs fixed except the receive idle flag
// Notes: Tick counts start one edge after the divisor write is taken
`timescale 1ns/1ps
`define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin fails++; \
   $display("wrong value at %0t: %h expected %h", $time, got, exp); end end
module sbrg_top_test;
   import sbrg_pkg::*;
   logic i_mclk;
   logic i_reset_n;
   sbrg_avl_req_s avl;
   logic waitreq;
   logic [SBRG_DATA_W-1:0] rdata;
   logic tick;
   logic [SBRG_DIV_W-1:0] divisor;
   logic wide;
   logic idle;
   logic sync;
   logic hs;
   logic pol;
   logic wake;
   logic abd;
   logic [7:0] tsc;
   logic [7:0] rsc;
   int fails;
   int checked;
   sbrg_top dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_avl(avl),
      .o_avl_waitrequest(waitreq), .o_avl_readdata(rdata), .i_receive_idle_flag(idle),
      .i_autobaud_overflow(1'b0), .i_transmit_shift_empty(1'b1), .i_frame_error(1'b1),
      .i_overrun_error(1'b0), .o_baud_tick(tick), .o_divisor(divisor), .o_sync_mode(sync),
      .o_high_speed_select(hs), .o_wide_counter_select(wide), .o_clock_polarity(pol),
      .o_wake_enable(wake), .o_autobaud_enable(abd), .o_transmit_status_control(tsc),
      .o_receive_status_control(rsc));
   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end
   task automatic print_verdict();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d,
         output logic [31:0] q);
      int k;
      avl.read <= rd;
      avl.write <= !rd;
      avl.address <= a;
      avl.writedata <= {24'h000000, d};
      k = 0;
      do begin
         @(posedge i_mclk);
         k++;
      end while (waitreq !== 1'b0 && k < 100);
      if (k >= 100) begin
         fails++;
         print_verdict();
      end
      q = rdata;
      avl.read <= 1'b0;
      avl.write <= 1'b0;
      @(posedge i_mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b0, a, d, q);
   endtask
   task automatic wait_tick(output int k);
      k = 0;
      do begin
         @(posedge i_mclk);
         k++;
      end while (tick !== 1'b1 && k < 20000);
      if (k >= 20000) begin
         fails++;
         print_verdict();
      end
   endtask
   task automatic do_reset();
      i_reset_n <= 1'b0;
      repeat (5) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      @(posedge i_mclk);
   endtask
   task automatic t_registers();
      logic [31:0] q;
      `CHECK(wide, 1'b0)
      bus(1'b1, SBRG_BAUD_CONTROL_ADDR, 8'h00, q);
      `CHECK(q, 32'h00000040)
      bus(1'b1, SBRG_TRANSMIT_STATUS_CONTROL_ADDR, 8'h00, q);
      `CHECK(q, 32'h00000002)
      bus(1'b1, SBRG_RECEIVE_STATUS_CONTROL_ADDR, 8'h00, q);
      `CHECK(q, 32'h00000004)
      bus(1'b1, 8'h20, 8'h00, q);
      `CHECK(q, 32'h00000000)
      wr(SBRG_BAUD_CONTROL_ADDR, 8'hFF);
      bus(1'b1, SBRG_BAUD_CONTROL_ADDR, 8'h00, q);
      `CHECK(q, 32'h0000005B)
      `CHECK(wide, 1'b1)
      `CHECK({pol, wake, abd}, 3'b111)
      // Receiver busy: software must see it before a clock change
      idle <= 1'b0;
      bus(1'b1, SBRG_BAUD_CONTROL_ADDR, 8'h00, q);
      idle <= 1'b1;
      `CHECK(q, 32'h0000001B)
      wr(SBRG_TRANSMIT_STATUS_CONTROL_ADDR, 8'hFF);
      `CHECK(tsc, 8'hFD)
      `CHECK({sync, hs}, 2'b11)
      wr(SBRG_RECEIVE_STATUS_CONTROL_ADDR, 8'hFF);
      `CHECK(rsc, 8'hF9)
      wr(SBRG_DIVISOR_HIGH_BYTE_ADDR, 8'hA5);
      wr(SBRG_DIVISOR_LOW_BYTE_ADDR, 8'h5A);
      bus(1'b1, SBRG_TIMER_COUNT_ADDR, 8'h00, q);
      `CHECK(q[31:16], 16'h0000)
      bus(1'b1, SBRG_DIVISOR_LOW_BYTE_ADDR, 8'h00, q);
      `CHECK(q, 32'h0000005A)
      bus(1'b1, SBRG_DIVISOR_HIGH_BYTE_ADDR, 8'h00, q);
      `CHECK(q, 32'h000000A5)
      // Write without the low byte lane is ignored
      avl.byteenable <= 4'hE;
      wr(SBRG_DIVISOR_LOW_BYTE_ADDR, 8'h00);
      avl.byteenable <= 4'hF;
      `CHECK(divisor, 16'hA55A)
   endtask
   task automatic t_rate(input logic s, input logic w, input logic h, input logic [7:0] hi,
         input logic [7:0] lo);
      int m;
      int n;
      int k;
      m = s ? 4 : (w ? (h ? 4 : 16) : (h ? 16 : 64));
      n = w ? int'({hi, lo}) : int'(lo);
      wr(SBRG_TRANSMIT_STATUS_CONTROL_ADDR, {3'b000, s, 1'b0, h, 2'b00});
      wr(SBRG_BAUD_CONTROL_ADDR, {4'h0, w, 3'b000});
      wr(SBRG_DIVISOR_HIGH_BYTE_ADDR, hi);
      wr(SBRG_DIVISOR_LOW_BYTE_ADDR, lo);
      `CHECK(divisor, w ? {hi, lo} : {8'h00, lo})
      `CHECK({sync, hs}, {s, h})
      wait_tick(k);
      `CHECK(k, m * (n + 1))
      wait_tick(k);
      `CHECK(k, m * (n + 1))
   endtask
   initial begin
      avl = '0;
      avl.byteenable = 4'hF;
      idle = 1'b1;
      i_reset_n = 1'b0;
      fails = 0;
      checked = 0;
      do_reset();
      t_registers();
      // All mode codes: sync, wide, high speed
      for (int i = 0; i < 8; i++) begin
         t_rate(i[2], i[1], i[0], 8'h01, 8'h02 + 8'(i));
      end
      t_rate(1'b1, 1'b0, 1'b1, 8'h03, 8'h00);
      do_reset();
      `CHECK(wide, 1'b0)
      `CHECK(divisor, 16'h0000)
      t_rate(1'b0, 1'b0, 1'b0, 8'h00, 8'h01);
      print_verdict();
   end
endmodule // sbrg_top_test
